// [verif/rxo_framer_model.sv]
/*
 rxo_framer_model: far-end framer capturing recovered data per channel.
 assumes: driven by rxo_rx_output; the bench picks the capture edge.
*/
`timescale 1ns/10ps
module rxo_framer_model #(
    parameter int NUM_CH = 3
) (
    // terminal side of the stage
    input wire rxo_pkg::rxo_rx_out_t [NUM_CH-1:0] rx_out,
    // capture edge, high for rising
    input wire logic                          sample_on_rise
);
    import rxo_pkg::*;
    logic [1:0] cap [NUM_CH][$];
    for (genvar k = 0; k < NUM_CH; k++) begin : g_ch
        // take data half a period away from its update edge
        always @(posedge rx_out[k].recovered_rx_clock) begin
            if (sample_on_rise) begin
                cap[k].push_back({rx_out[k].rx_negative_out, rx_out[k].rx_positive_out});
            end
        end
        always @(negedge rx_out[k].recovered_rx_clock) begin
            if (!sample_on_rise) begin
                cap[k].push_back({rx_out[k].rx_negative_out, rx_out[k].rx_positive_out});
            end
        end
    end
endmodule : rxo_framer_model

// [verif/rxo_rx_output_tb.sv]
/*
 rxo_rx_output_tb: self-checking bench of the receive output stage.
 assumes: ch0 decodes b3zs, ch1 hdb3, ch2 has decoding held off.
*/
`timescale 1ns/10ps
module rxo_rx_output_tb;
    import rxo_pkg::*;
    typedef logic [1:0] rxo_sym_q_t [$];
    logic               core_clk = 0;
    logic               rstn = 0;
    logic               host_mode_pin = 0;
    logic               shared_select_pin = 1;
    logic               single_dual_rail_select = 0;
    logic               cmd_wr_en = 0;
    logic               sample_on_rise = 0;
    rxo_cmd_t           cmd_wr_data = '0;
    rxo_cmd_t           cmd_state;
    rxo_line_in_t [2:0] line_in;
    rxo_rx_out_t  [2:0] rx_out;
    int                 n_errors = 0;
    int                 n_compared = 0;
    int                 cycles = 0;
    rxo_sym_q_t         dual_s = '{2'h1, 2'h2, 2'h1, 2'h1, 2'h2, 2'h2,
                                   2'h0, 2'h1, 2'h0, 2'h2, 2'h0, 2'h0};
    rxo_sym_q_t         single_s = '{2'h1, 2'h2, 2'h0, 2'h0, 2'h2, 2'h1, 2'h2, 2'h0, 2'h2, 2'h1,
                                     2'h0, 2'h0, 2'h1, 2'h2, 2'h0, 2'h0, 2'h2, 2'h0, 2'h0, 2'h0};

    rxo_rx_output #(.NUM_CH(3)) i_rxo_rx_output (.core_clk(core_clk), .rstn(rstn),
        .host_mode_pin(host_mode_pin), .shared_select_pin(shared_select_pin),
        .single_dual_rail_select(single_dual_rail_select), .cmd_wr_en(cmd_wr_en),
        .cmd_wr_data(cmd_wr_data), .line_in(line_in), .rx_out(rx_out),
        .cmd_state(cmd_state));
    rxo_framer_model #(.NUM_CH(3)) i_rxo_framer_model (.rx_out(rx_out),
        .sample_on_rise(sample_on_rise));

    always #2 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            summarize();
        end
    end

    task automatic summarize;
        $display("errors=%0d compared=%0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : summarize

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wait_clk(input int n);
        repeat (n) @(negedge core_clk);
    endtask : wait_clk

    task automatic set_mode(input logic host, input logic sel, input logic single);
        rstn = 0;
        wait_clk(20);
        rstn = 1;
        host_mode_pin = host;
        shared_select_pin = sel;
        single_dual_rail_select = single;
        wait_clk(8);
    endtask : set_mode

    task automatic wr(input logic [1:0] v);
        cmd_wr_data = v;
        cmd_wr_en = 1;
        wait_clk(1);
        cmd_wr_en = 0;
        wait_clk(3);
    endtask : wr

    task automatic set_line(input logic c, input logic [1:0] v);
        for (int k = 0; k < 3; k++) begin
            line_in[k].line_clk = c;
            line_in[k].line_in_tip = v[0];
            line_in[k].line_in_ring = v[1];
        end
    endtask : set_line

    // decoder reference: drop v, clear the pulse 2 or 3 back on its rail
    function automatic rxo_sym_q_t model(rxo_sym_q_t s, logic single, logic dec, logic hdb);
        rxo_sym_q_t d;
        rxo_sym_q_t e;
        int         last;
        int         p;
        int         b;
        d = s;
        last = -1;
        b = hdb ? 3 : 2;
        foreach (s[i]) if (s[i] != 0) begin
            p = s[i][0] ? 0 : 1;
            if (dec && last == p) begin
                d[i] = 0;
                if (i >= b) d[i-b][p] = 0;
            end
            last = p;
        end
        foreach (s[i]) e.push_back(i < 4 ? 2'h0 : (single ? {1'b0, |d[i-4]} : d[i-4]));
        return e;
    endfunction : model

    task automatic send(input rxo_sym_q_t s);
        rxo_sym_q_t e;
        logic [1:0] got;
        for (int k = 0; k < 3; k++) i_rxo_framer_model.cap[k].delete();
        #1.3;
        foreach (s[j]) begin
            set_line(0, s[j]);
            #62.5;
            set_line(1, s[j]);
            #62.5;
        end
        set_line(0, 2'h0);
        wait_clk(10);
        for (int k = 0; k < 3; k++) begin
            // decoder needs single rail as well as a grounded tx negative
            e = model(s, single_dual_rail_select, single_dual_rail_select && k != 2, k == 1);
            chk(8'(i_rxo_framer_model.cap[k].size()), 8'(s.size()));
            foreach (e[j]) begin
                got = i_rxo_framer_model.cap[k][j];
                chk({6'h00, got}, {6'h00, e[j]});
            end
        end
    endtask : send

    task automatic t_dual;
        set_mode(0, 0, 0);
        sample_on_rise = 0;
        for (int k = 0; k < 3; k++) begin
            chk({7'h00, rx_out[k].equalizer_on}, {7'h00, k != 1});
        end
        send(dual_s);
        $display("test dual done");
    endtask : t_dual

    task automatic t_single;
        set_mode(0, 0, 1);
        send(single_s);
        $display("test single done");
    endtask : t_single

    task automatic t_hwinv;
        set_mode(0, 1, 0);
        sample_on_rise = 1;
        for (int k = 0; k < 3; k++) begin
            chk({7'h00, rx_out[k].recovered_rx_clock}, 8'h01);
        end
        send(dual_s);
        $display("test invert done");
    endtask : t_hwinv

    task automatic t_host;
        set_mode(1, 1, 0);
        // pins held high on purpose to show they are ignored
        for (int k = 0; k < 3; k++) line_in[k].equalizer_enable_pin = 1;
        wr(2'h1);
        chk({6'h00, cmd_state}, 8'h01);
        for (int k = 0; k < 3; k++) begin
            chk({6'h00, rx_out[k].recovered_rx_clock, rx_out[k].equalizer_on}, 8'h00);
        end
        send(dual_s);
        wr(2'h3);
        for (int k = 0; k < 3; k++) chk({7'h00, rx_out[k].equalizer_on}, 8'h01);
        shared_select_pin = 0;
        wait_clk(8);
        chk({6'h00, cmd_state}, 8'h00);
        wr(2'h3);
        chk({6'h00, cmd_state}, 8'h00);
        shared_select_pin = 1;
        $display("test host done");
    endtask : t_host

    initial begin
        for (int k = 0; k < 3; k++) begin
            line_in[k] = '0;
            line_in[k].tx_negative_in = (k == 2);
            line_in[k].equalizer_enable_pin = (k != 1);
            line_in[k].hdb3_select = (k == 1);
        end
        t_dual();
        t_single();
        t_hwinv();
        t_host();
        summarize();
    end
endmodule : rxo_rx_output_tb

// [verilog/rxo_cfg.svh]
/*
 rxo_cfg.svh: constants for the receive output stage.
 assumes: included by bare name before the package.
*/
`ifndef RXO_CFG_SVH
`define RXO_CFG_SVH
`define RXO_NUM_CH      3
`define RXO_PIPE_DEPTH  4
`define RXO_B3ZS_B_POS  2
`define RXO_HDB3_B_POS  3
`define RXO_CMD_INV_BIT 0
`define RXO_CMD_EQ_BIT  1
`define RXO_CMD_RESET   2'h0
`endif

// [verilog/rxo_pkg.sv]
/*
 rxo_pkg: carrier types of the receive output stage.
 assumes: rxo_cfg.svh is on the include path.
*/
`include "rxo_cfg.svh"
package rxo_pkg;
    // per-channel pins coming in
    typedef struct packed {
        logic line_clk;
        logic line_in_tip;
        logic line_in_ring;
        logic tx_negative_in;
        logic equalizer_enable_pin;
        logic hdb3_select;
    } rxo_line_in_t;

    // per-channel pins going out
    typedef struct packed {
        logic recovered_rx_clock;
        logic rx_positive_out;
        logic rx_negative_out;
        logic equalizer_on;
    } rxo_rx_out_t;

    // command register image
    typedef struct packed {
        logic eq_on;
        logic clk_inv;
    } rxo_cmd_t;

    typedef struct packed {
        logic [2:0]                 clk_sync;
        logic [1:0]                 tip_sync;
        logic [1:0]                 ring_sync;
        logic [1:0]                 txn_sync;
        logic [1:0]                 eq_sync;
        logic [1:0]                 hdb_sync;
        logic [`RXO_PIPE_DEPTH-1:0] pipe_pos;
        logic [`RXO_PIPE_DEPTH-1:0] pipe_neg;
        logic                       last_neg;
        logic                       seen_pulse;
        rxo_rx_out_t                out;
    } rxo_chan_t;
endpackage : rxo_pkg

// [verilog/rxo_rx_output.sv]
/*
 rxo_rx_output: recovered clock and data output stage, all channels.
 assumes: line clock, tip/ring slicer levels and mode pins are asynchronous
 to core_clk and much slower (link clock about 8 MHz against 250 MHz).
*/
`timescale 1ns/10ps
`include "rxo_cfg.svh"

// Notes on behaviour
// R01 - Each channel drives a recovered clock output that times its data outputs.
// R02 - By default the data outputs change on the rising edge of that clock.
// R03 - In host mode a set invert bit in the command register moves updates to the falling edge.
// R04 - In hardware mode a high select pin inverts the clock and updates data on its falling edge.
// R05 - In hardware mode a low select pin keeps data updates on the rising edge.
// R06 - Each positive line pulse gives a high pulse on the positive data output.
// R07 - In dual rail each negative line pulse gives a high pulse on the negative data output.
// R08 - With the decoder on, zero substitution patterns come out as zeros.
// R09 - In hardware mode the equalizer pin turns the equalizer on when high, bypass when low.
// R10 - In host mode the equalizer pin is ignored and should be held at ground.
// R11 - In host mode a low reset pin returns the command register to its defaults.
// R12 - The shared pin is register reset in host mode, clock invert select in hardware mode.
// R13 - The rail select pin chooses single rail when high and dual rail when low.
// R14 - The far end holds its transmit negative input low to enable decoding in single rail.
// R15 - With the decoder off every received pulse passes through unchanged.
module rxo_rx_output #(
    parameter int NUM_CH = `RXO_NUM_CH
) (
    // clock and reset
    input  wire logic                             core_clk,
    input  wire logic                             rstn,
    // device mode pins
    input  wire logic                             host_mode_pin,
    input  wire logic                             shared_select_pin,
    input  wire logic                             single_dual_rail_select,
    // command register write, core_clk domain
    input  wire logic                             cmd_wr_en,
    input  wire rxo_pkg::rxo_cmd_t                cmd_wr_data,
    // per-channel line side
    input  wire rxo_pkg::rxo_line_in_t [NUM_CH-1:0] line_in,
    // per-channel terminal side
    output rxo_pkg::rxo_rx_out_t       [NUM_CH-1:0] rx_out,
    // command register read back
    output rxo_pkg::rxo_cmd_t                     cmd_state
);
    import rxo_pkg::*;

    if (NUM_CH < 1 || NUM_CH > 8) begin : g_bad_param
        $error("rxo_rx_output: NUM_CH must be 1 to 8");
    end

    typedef struct packed {
        logic [1:0]              host_sync;
        logic [1:0]              shr_sync;
        logic [1:0]              rail_sync;
        rxo_cmd_t                cmd;
        rxo_chan_t [NUM_CH-1:0]  ch;
    } rxo_state_t;

    rxo_state_t state_reg;
    rxo_state_t state_next;

    // decoded modes, from synchronised pins only
    logic host_m;
    logic single_m;
    logic hw_inv;
    logic reg_clr;
    logic [NUM_CH-1:0] rise;
    logic [NUM_CH-1:0] fall;
    logic [NUM_CH-1:0] dec_on;
    logic [NUM_CH-1:0] viol;

    always_comb begin
        host_m   = state_reg.host_sync[1];
        single_m = state_reg.rail_sync[1];                          // see R13
        hw_inv   = !host_m && state_reg.shr_sync[1];                // see R12
        reg_clr  = host_m && !state_reg.shr_sync[1];                // see R12
        for (int i = 0; i < NUM_CH; i++) begin
            rise[i] = state_reg.ch[i].clk_sync[1] && !state_reg.ch[i].clk_sync[2];
            fall[i] = !state_reg.ch[i].clk_sync[1] && state_reg.ch[i].clk_sync[2];
            // decoder only in single rail with far end tx negative at ground
            dec_on[i] = single_m && !state_reg.ch[i].txn_sync[1];   // see R14
        end
    end

    // substitution clean-up: violation drops V and its balancing B
    function automatic logic [`RXO_PIPE_DEPTH-1:0] rxo_strip(
        input logic [`RXO_PIPE_DEPTH-1:0] pipe,
        input logic                       hit,
        input logic                       hdb3
    );
        logic [`RXO_PIPE_DEPTH-1:0] res;
        res = pipe;
        if (hit) begin
            res[0] = 1'b0;                                          // see R08
            if (hdb3) begin
                res[`RXO_HDB3_B_POS] = 1'b0;                        // see R08
            end else begin
                res[`RXO_B3ZS_B_POS] = 1'b0;                        // see R08
            end
        end
        return res;
    endfunction : rxo_strip

    always_comb begin
        logic p;
        logic n;
        logic upd;
        logic [`RXO_PIPE_DEPTH-1:0] np;
        logic [`RXO_PIPE_DEPTH-1:0] nn;
        p   = 1'b0;
        n   = 1'b0;
        upd = 1'b0;
        np  = '0;
        nn  = '0;
        viol = '0;
        state_next = state_reg;
        state_next.host_sync = {state_reg.host_sync[0], host_mode_pin};
        state_next.shr_sync  = {state_reg.shr_sync[0], shared_select_pin};
        state_next.rail_sync = {state_reg.rail_sync[0], single_dual_rail_select};

        // command register; the pin reset beats a write
        if (reg_clr) begin
            state_next.cmd = rxo_cmd_t'(`RXO_CMD_RESET);            // see R11
        end else if (cmd_wr_en) begin
            state_next.cmd = cmd_wr_data;
        end

        for (int i = 0; i < NUM_CH; i++) begin
            state_next.ch[i].clk_sync  = {state_reg.ch[i].clk_sync[1:0], line_in[i].line_clk};
            state_next.ch[i].tip_sync  = {state_reg.ch[i].tip_sync[0], line_in[i].line_in_tip};
            state_next.ch[i].ring_sync = {state_reg.ch[i].ring_sync[0], line_in[i].line_in_ring};
            state_next.ch[i].txn_sync  = {state_reg.ch[i].txn_sync[0], line_in[i].tx_negative_in};
            state_next.ch[i].eq_sync   = {state_reg.ch[i].eq_sync[0],
                                          line_in[i].equalizer_enable_pin};
            state_next.ch[i].hdb_sync  = {state_reg.ch[i].hdb_sync[0], line_in[i].hdb3_select};

            // tip wins when both slicers fire: one symbol per bit slot
            p = state_reg.ch[i].tip_sync[1];                        // see R06
            n = state_reg.ch[i].ring_sync[1] && !p;                 // see R07
            viol[i] = dec_on[i] && (p || n) && state_reg.ch[i].seen_pulse
                      && (n == state_reg.ch[i].last_neg);

            // line symbols are taken on the line clock rising edge
            if (rise[i]) begin
                np = {state_reg.ch[i].pipe_pos[`RXO_PIPE_DEPTH-2:0], p};
                nn = {state_reg.ch[i].pipe_neg[`RXO_PIPE_DEPTH-2:0], n};
                // decoder off: shift only, patterns kept
                state_next.ch[i].pipe_pos = rxo_strip(np, viol[i] && !n,
                                                      state_reg.ch[i].hdb_sync[1]); // see R15
                state_next.ch[i].pipe_neg = rxo_strip(nn, viol[i] && n,
                                                      state_reg.ch[i].hdb_sync[1]); // see R15
                if (p || n) begin
                    state_next.ch[i].last_neg   = n;
                    state_next.ch[i].seen_pulse = 1'b1;
                end
            end

            // clock out is inverted only by the hardware select
            state_next.ch[i].out.recovered_rx_clock =
                state_reg.ch[i].clk_sync[1] ^ hw_inv;               // see R01
            // hardware invert: inverted clock falls at the line rise
            if (host_m && state_reg.cmd.clk_inv) begin
                upd = fall[i];                                      // see R03
            end else begin
                upd = rise[i];                                      // see R02
            end
            if (upd) begin
                p = state_reg.ch[i].pipe_pos[`RXO_PIPE_DEPTH-1];
                n = state_reg.ch[i].pipe_neg[`RXO_PIPE_DEPTH-1];
                if (single_m) begin
                    state_next.ch[i].out.rx_positive_out = p || n;  // see R13
                    state_next.ch[i].out.rx_negative_out = 1'b0;
                end else begin
                    state_next.ch[i].out.rx_positive_out = p;       // see R06
                    state_next.ch[i].out.rx_negative_out = n;       // see R07
                end
            end

            if (host_m) begin
                state_next.ch[i].out.equalizer_on = state_reg.cmd.eq_on; // see R10
            end else begin
                state_next.ch[i].out.equalizer_on = state_reg.ch[i].eq_sync[1]; // see R09
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            rx_out[i] = state_reg.ch[i].out;
        end
        cmd_state = state_reg.cmd;
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    // watched on channel 0; all channels share one body
    logic c0_pos;
    logic c0_neg;
    logic c0_clk;
    logic c0_eq;
    logic c0_hinv;
    assign c0_pos  = state_reg.ch[0].out.rx_positive_out;
    assign c0_neg  = state_reg.ch[0].out.rx_negative_out;
    assign c0_clk  = state_reg.ch[0].out.recovered_rx_clock;
    assign c0_eq   = state_reg.ch[0].out.equalizer_on;
    assign c0_hinv = host_m && state_reg.cmd.clk_inv;

    property p_clk_follow;
        $past(host_m) == host_m && $past(hw_inv) == hw_inv
        |-> c0_clk == ($past(state_reg.ch[0].clk_sync[1]) ^ hw_inv);
    endproperty
    a_clk_follow: assert property (p_clk_follow) // see R01
        else $error("recovered clock does not follow the line clock");

    property p_host_rise;
        host_m && !c0_hinv && $past(host_m) && !$past(c0_hinv)
        && ($changed(c0_pos) || $changed(c0_neg)) |-> $past(rise[0]);
    endproperty
    a_host_rise: assert property (p_host_rise) // see R02
        else $error("data changed away from rising clock edge");

    property p_host_fall;
        c0_hinv && $past(c0_hinv) && ($changed(c0_pos) || $changed(c0_neg))
        |-> $past(fall[0]) && !c0_clk;
    endproperty
    a_host_fall: assert property (p_host_fall) // see R03
        else $error("host invert: data changed away from falling edge");

    property p_hw_inv;
        hw_inv && $past(hw_inv, 2) && ($changed(c0_pos) || $changed(c0_neg))
        |-> $fell(c0_clk);
    endproperty
    a_hw_inv: assert property (p_hw_inv) // see R04
        else $error("hardware invert: data not on clock falling edge");

    property p_hw_rise;
        !host_m && !hw_inv && $past(!host_m && !hw_inv, 2)
        && ($changed(c0_pos) || $changed(c0_neg)) |-> $rose(c0_clk);
    endproperty
    a_hw_rise: assert property (p_hw_rise) // see R05
        else $error("hardware: data not on clock rising edge");

    property p_neg_sample;
        rise[0] && !viol[0] && state_reg.ch[0].ring_sync[1] && !state_reg.ch[0].tip_sync[1]
        |=> state_reg.ch[0].pipe_neg[0] && !state_reg.ch[0].pipe_pos[0];
    endproperty
    a_neg_sample: assert property (p_neg_sample) // see R07
        else $error("negative line pulse lost");

    property p_pos_sample;
        rise[0] && !viol[0] && state_reg.ch[0].tip_sync[1]
        |=> state_reg.ch[0].pipe_pos[0];
    endproperty
    a_pos_sample: assert property (p_pos_sample) // see R06
        else $error("positive line pulse lost");

    property p_viol_drop;
        rise[0] && viol[0] |=> !state_reg.ch[0].pipe_pos[0] && !state_reg.ch[0].pipe_neg[0];
    endproperty
    a_viol_drop: assert property (p_viol_drop) // see R08
        else $error("violation pulse reached the pipeline");

    property p_no_dec_pass;
        rise[0] && !dec_on[0] && (state_reg.ch[0].tip_sync[1] || state_reg.ch[0].ring_sync[1])
        |=> state_reg.ch[0].pipe_pos[0] || state_reg.ch[0].pipe_neg[0];
    endproperty
    a_no_dec_pass: assert property (p_no_dec_pass) // see R15
        else $error("decoder off but pulse removed");

    property p_eq_hw;
        !host_m && $past(!host_m) |-> c0_eq == $past(state_reg.ch[0].eq_sync[1]);
    endproperty
    a_eq_hw: assert property (p_eq_hw) // see R09
        else $error("hardware equalizer does not follow pin");

    property p_eq_host;
        host_m && $past(host_m) |-> c0_eq == $past(state_reg.cmd.eq_on);
    endproperty
    a_eq_host: assert property (p_eq_host) // see R10
        else $error("host equalizer does not follow command bit");

    property p_reg_clr;
        reg_clr |=> state_reg.cmd == rxo_cmd_t'(`RXO_CMD_RESET);
    endproperty
    a_reg_clr: assert property (p_reg_clr) // see R11
        else $error("command register not cleared by reset pin");

    property p_single;
        single_m && $past(single_m) |-> !c0_neg;
    endproperty
    a_single: assert property (p_single) // see R13
        else $error("single rail drives negative output");
endmodule : rxo_rx_output
